// *** design/lopm_pkg.sv ***
package lopm_pkg;

  ////////////////////////////////////////////////////////////////////////
  // Clock and waveform timing
  localparam int CLK_HZ          = 40_000_000;
  localparam int PWM_STEPS       = 256;
  localparam int IND_PWM_HZ      = 97_000;
  localparam int GRP_DIM_HZ      = 190;
  localparam int GRP_BLINK_HZ    = 24;
  localparam int IND_PRESC_RAW   = CLK_HZ / (IND_PWM_HZ * PWM_STEPS);
  localparam int IND_PRESC       = (IND_PRESC_RAW < 1) ? 1 : IND_PRESC_RAW;
  localparam int GRP_DIM_PRESC   = CLK_HZ / (GRP_DIM_HZ * PWM_STEPS);
  localparam int GRP_BLINK_PRESC = CLK_HZ / (GRP_BLINK_HZ * PWM_STEPS);
  localparam int PRESC_W         = 24;

  ////////////////////////////////////////////////////////////////////////
  // Register offsets
  localparam logic [7:0] ADDR_OUTCFG     = 8'h01;
  localparam logic [7:0] ADDR_CH_BASE    = 8'h02;
  localparam logic [7:0] ADDR_GRP_DUTY   = 8'h12;
  localparam logic [7:0] ADDR_GRP_PERIOD = 8'h13;
  localparam logic [7:0] ADDR_CODE_BASE  = 8'h14;
  localparam logic [7:0] ADDR_STATUS     = 8'h18;

  ////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int BIT_BLINK  = 5;
  localparam int BIT_INVERT = 4;
  localparam int BIT_STAGE  = 2;
  localparam int DIS_LSB    = 0;
  localparam int BIT_ST_OE  = 7;
  localparam int BIT_ST_GRP = 6;

  ////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [7:0] RST_CH_DUTY    = 8'h00;
  localparam logic [7:0] RST_GRP_DUTY   = 8'hFF;
  localparam logic [7:0] RST_GRP_PERIOD = 8'h00;
  localparam logic [1:0] RST_CODE       = 2'h0;
  localparam logic [7:0] RST_OUTCFG     = 8'h04;

  ////////////////////////////////////////////////////////////////////////
  // Codes
  localparam logic [1:0] CODE_OFF  = 2'h0;
  localparam logic [1:0] CODE_ON   = 2'h1;
  localparam logic [1:0] CODE_IND  = 2'h2;
  localparam logic [1:0] CODE_GRP  = 2'h3;
  localparam logic [1:0] DIS_LOW   = 2'h0;
  localparam logic [1:0] DIS_HIGH  = 2'h1;

  typedef struct packed {
    logic       group_blink;
    logic       output_polarity_invert;
    logic       output_stage_type;
    logic [1:0] disabled_output_state;
  } lopm_cfg_t;

  typedef struct packed {
    logic out;
    logic oe;
  } lopm_drv_t;

endpackage

// *** design/lopm_pin_cell.sv ***
`timescale 1ns/10ps
`default_nettype none
module lopm_pin_cell
  import lopm_pkg::*;
(
  input  wire logic [7:0] channel_duty_value,
  input  wire logic [7:0] ind_count,
  input  wire logic [1:0] pin_output_state_code,
  input  wire logic       group_active,
  input  wire lopm_cfg_t  cfg,
  input  wire logic       output_enable_n,
  output var  lopm_drv_t  drv
);

  logic ind_active;
  logic src;
  logic act;

  always_comb begin
    ind_active = ind_count < channel_duty_value;
    case (pin_output_state_code)
      CODE_OFF: src = 1'b0;
      CODE_ON:  src = 1'b1;
      CODE_IND: src = ind_active;
      CODE_GRP: src = ind_active & group_active;
      default:  src = 1'b0;
    endcase
    act = src ^ cfg.output_polarity_invert;
    drv = '{out: 1'b0, oe: 1'b0};
    if (output_enable_n) begin
      case (cfg.disabled_output_state)
        DIS_LOW:  drv = '{out: 1'b0, oe: 1'b1};
        DIS_HIGH: drv = '{out: 1'b1, oe: cfg.output_stage_type};
        default:  drv = '{out: 1'b1, oe: 1'b0};
      endcase
    end else if (act) begin
      drv = '{out: 1'b0, oe: 1'b1};
    end else begin
      drv = '{out: 1'b1, oe: cfg.output_stage_type};
    end
  end

endmodule // lopm_pin_cell
`default_nettype wire

// *** design/lopm_led_output_pwm_mixer.sv ***
// Notes on behaviour
// - Code 11, no invert, open drain: upper off, lower follows individual AND group PWM.
// - Code 11, no invert, totem pole: pin driven low or high by the combined PWM.
// - Code 11, invert, open drain: upper off, lower follows the inverted combined PWM.
// - Code 11, invert, totem pole: pin driven by the complement of the combined PWM.
// - With the active-low enable high, every pin follows the disabled output state field, and for state 01 also the output stage type.
// - Each channel has an 8-bit, 256-step brightness PWM at about 156 kHz (40 MHz / 256).
// - One shared group signal, dimming or blinking, is mixed into selected outputs.
// - Group dimming runs near 190 Hz with an 8-bit group duty.
// - Group blinking period spans 24 Hz to about 10.7 s in 256 steps, with its own duty.
// - Pin code 00 off, 01 on, 10 individual PWM, 11 individual with group.
// - Polarity invert acts only while the enable input is low.
`timescale 1ns/10ps
`default_nettype none
module lopm_led_output_pwm_mixer
  import lopm_pkg::*;
#(
  parameter int NUM_CH      = 16,
  parameter int BLINK_PRESC = GRP_BLINK_PRESC
) (
  input  wire logic              clk,
  input  wire logic              reset_n,
  input  wire logic [7:0]        reg_addr,
  input  wire logic [7:0]        reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  input  wire logic              output_enable_n,
  output logic [7:0]             reg_rdata,
  output logic [NUM_CH-1:0]      led_pin_out,
  output logic [NUM_CH-1:0]      led_pin_oe
);

  localparam int CODE_REGS = (NUM_CH + 3) / 4;

  ////////////////////////////////////////////////////////////////////////
  // Register file
  logic [7:0]  duty_q   [NUM_CH];
  logic [7:0]  duty_d   [NUM_CH];
  logic [1:0]  code_q   [NUM_CH];
  logic [1:0]  code_d   [NUM_CH];
  logic [7:0]  cfg_raw_q;
  logic [7:0]  cfg_raw_d;
  logic [7:0]  grp_duty_q;
  logic [7:0]  grp_duty_d;
  logic [7:0]  grp_period_q;
  logic [7:0]  grp_period_d;
  logic [7:0]  rdata_q;
  logic [7:0]  rdata_d;
  logic [7:0]  ch_off;
  logic [7:0]  code_off;
  lopm_cfg_t   cfg;
  logic        grp_active;

  assign cfg = '{group_blink:            cfg_raw_q[BIT_BLINK],
                 output_polarity_invert: cfg_raw_q[BIT_INVERT],
                 output_stage_type:      cfg_raw_q[BIT_STAGE],
                 disabled_output_state:  cfg_raw_q[DIS_LSB+1:DIS_LSB]};

  always_comb begin
    ch_off       = reg_addr - ADDR_CH_BASE;
    code_off     = reg_addr - ADDR_CODE_BASE;
    duty_d       = duty_q;
    code_d       = code_q;
    cfg_raw_d    = cfg_raw_q;
    grp_duty_d   = grp_duty_q;
    grp_period_d = grp_period_q;
    rdata_d      = 8'h00;
    if (reg_wr) begin
      if (reg_addr == ADDR_OUTCFG) begin
        cfg_raw_d = reg_wdata & 8'h37;
      end
      if (reg_addr == ADDR_GRP_DUTY) begin
        grp_duty_d = reg_wdata;
      end
      if (reg_addr == ADDR_GRP_PERIOD) begin
        grp_period_d = reg_wdata;
      end
      for (int i = 0; i < NUM_CH; i++) begin
        if (ch_off == 8'(i)) begin
          duty_d[i] = reg_wdata;
        end
        if (code_off == 8'(i / 4)) begin
          code_d[i] = reg_wdata[2*(i%4) +: 2];
        end
      end
    end
    if (reg_rd) begin
      if (reg_addr == ADDR_OUTCFG) begin
        rdata_d = cfg_raw_q;
      end
      if (reg_addr == ADDR_GRP_DUTY) begin
        rdata_d = grp_duty_q;
      end
      if (reg_addr == ADDR_GRP_PERIOD) begin
        rdata_d = grp_period_q;
      end
      if (reg_addr == ADDR_STATUS) begin
        rdata_d[BIT_ST_OE]  = output_enable_n;
        rdata_d[BIT_ST_GRP] = grp_active;
      end
      for (int i = 0; i < NUM_CH; i++) begin
        if (ch_off == 8'(i)) begin
          rdata_d = duty_q[i];
        end
      end
      for (int k = 0; k < CODE_REGS; k++) begin
        if (code_off == 8'(k)) begin
          for (int j = 0; j < 4; j++) begin
            if (4*k + j < NUM_CH) begin
              rdata_d[2*j +: 2] = code_q[4*k + j];
            end
          end
        end
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < NUM_CH; i++) begin
        duty_q[i] <= RST_CH_DUTY;
        code_q[i] <= RST_CODE;
      end
      cfg_raw_q    <= RST_OUTCFG;
      grp_duty_q   <= RST_GRP_DUTY;
      grp_period_q <= RST_GRP_PERIOD;
      rdata_q      <= 8'h00;
    end else begin
      duty_q       <= duty_d;
      code_q       <= code_d;
      cfg_raw_q    <= cfg_raw_d;
      grp_duty_q   <= grp_duty_d;
      grp_period_q <= grp_period_d;
      rdata_q      <= rdata_d;
    end
  end

  assign reg_rdata = rdata_q;

  ////////////////////////////////////////////////////////////////////////
  // Individual and group counters
  logic [PRESC_W-1:0] ind_pre_q;
  logic [PRESC_W-1:0] ind_pre_d;
  logic [7:0]         ind_cnt_q;
  logic [7:0]         ind_cnt_d;
  logic [PRESC_W-1:0] grp_pre_q;
  logic [PRESC_W-1:0] grp_pre_d;
  logic [7:0]         grp_step_q;
  logic [7:0]         grp_step_d;
  logic [7:0]         grp_cnt_q;
  logic [7:0]         grp_cnt_d;
  logic [PRESC_W-1:0] grp_limit;

  always_comb begin
    ind_pre_d  = ind_pre_q + 1'b1;
    ind_cnt_d  = ind_cnt_q;
    if (ind_pre_q == PRESC_W'(IND_PRESC - 1)) begin
      ind_pre_d = '0;
      ind_cnt_d = ind_cnt_q + 8'h01;
    end
    grp_limit  = cfg.group_blink ? PRESC_W'(BLINK_PRESC - 1) : PRESC_W'(GRP_DIM_PRESC - 1);
    grp_pre_d  = grp_pre_q + 1'b1;
    grp_step_d = grp_step_q;
    grp_cnt_d  = grp_cnt_q;
    if (grp_pre_q >= grp_limit) begin
      grp_pre_d = '0;
      if (!cfg.group_blink || grp_step_q >= grp_period_q) begin
        grp_step_d = 8'h00;
        grp_cnt_d  = grp_cnt_q + 8'h01;
      end else begin
        grp_step_d = grp_step_q + 8'h01;
      end
    end
    grp_active = grp_cnt_q < grp_duty_q;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ind_pre_q  <= '0;
      ind_cnt_q  <= 8'h00;
      grp_pre_q  <= '0;
      grp_step_q <= 8'h00;
      grp_cnt_q  <= 8'h00;
    end else begin
      ind_pre_q  <= ind_pre_d;
      ind_cnt_q  <= ind_cnt_d;
      grp_pre_q  <= grp_pre_d;
      grp_step_q <= grp_step_d;
      grp_cnt_q  <= grp_cnt_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Output stage
  lopm_drv_t        drv [NUM_CH];
  logic [NUM_CH-1:0] pin_out_d;
  logic [NUM_CH-1:0] pin_oe_d;
  logic [NUM_CH-1:0] pin_out_q;
  logic [NUM_CH-1:0] pin_oe_q;

  for (genvar g = 0; g < NUM_CH; g++) begin : g_pin
    lopm_pin_cell u_cell (
      .channel_duty_value    (duty_q[g]),
      .ind_count             (ind_cnt_q),
      .pin_output_state_code (code_q[g]),
      .group_active          (grp_active),
      .cfg                   (cfg),
      .output_enable_n       (output_enable_n),
      .drv                   (drv[g])
    );
  end

  always_comb begin
    for (int i = 0; i < NUM_CH; i++) begin
      pin_out_d[i] = drv[i].out;
      pin_oe_d[i]  = drv[i].oe;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pin_out_q <= '1;
      pin_oe_q  <= '0;
    end else begin
      pin_out_q <= pin_out_d;
      pin_oe_q  <= pin_oe_d;
    end
  end

  assign led_pin_out = pin_out_q;
  assign led_pin_oe  = pin_oe_q;

endmodule // lopm_led_output_pwm_mixer
`default_nettype wire

// *** tb/lopm_mixer_asserts.sv ***
`timescale 1ns/10ps
`default_nettype none
module lopm_mixer_asserts
  import lopm_pkg::*;
#(
  parameter int NUM_CH      = 16,
  parameter int BLINK_PRESC = GRP_BLINK_PRESC
) (
  input wire logic              clk,
  input wire logic              reset_n,
  input wire logic [7:0]        reg_addr,
  input wire logic [7:0]        reg_wdata,
  input wire logic              reg_wr,
  input wire logic              reg_rd,
  input wire logic              output_enable_n,
  input wire logic [7:0]        reg_rdata,
  input wire logic [NUM_CH-1:0] led_pin_out,
  input wire logic [NUM_CH-1:0] led_pin_oe
);
  logic [7:0] cfg_q;
  logic [7:0] cfg_d;
  logic [1:0] c0_q;
  logic [1:0] c0_d;
  always_comb begin
    cfg_d = cfg_q;
    c0_d  = c0_q;
    if (reg_wr && reg_addr == ADDR_OUTCFG) cfg_d = reg_wdata & 8'h37;
    if (reg_wr && reg_addr == ADDR_CODE_BASE) c0_d = reg_wdata[1:0];
  end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cfg_q <= RST_OUTCFG;
      c0_q  <= RST_CODE;
    end else begin
      cfg_q <= cfg_d;
      c0_q  <= c0_d;
    end
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  a_rd_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00) else $error("read data not idle");
  a_rd_cfg: assert property ($past(reg_rd && reg_addr == ADDR_OUTCFG && reset_n) |-> reg_rdata == $past(cfg_q))
    else $error("config readback wrong");
  a_dis_low: assert property ($past(reset_n && output_enable_n && cfg_q[1:0] == DIS_LOW) |->
    &led_pin_oe && led_pin_out == '0) else $error("disabled low state wrong");
  a_dis_high: assert property ($past(reset_n && output_enable_n && cfg_q[1:0] == DIS_HIGH) |->
    &led_pin_out && led_pin_oe == {NUM_CH{$past(cfg_q[BIT_STAGE])}}) else $error("disabled high state wrong");
  a_dis_float: assert property ($past(reset_n && output_enable_n && cfg_q[1]) |->
    &led_pin_out && led_pin_oe == '0) else $error("disabled float state wrong");
  a_od_no_high: assert property ($past(reset_n) && !$past(cfg_q[BIT_STAGE]) |->
    (led_pin_oe & led_pin_out) == '0) else $error("open drain drove high");
  a_totem_drive: assert property ($past(reset_n && !output_enable_n && cfg_q[BIT_STAGE]) |->
    &led_pin_oe) else $error("totem pole pin floating");
  a_code_off: assert property ($past(reset_n && !output_enable_n && c0_q == CODE_OFF) |->
    led_pin_out[0] == !$past(cfg_q[BIT_INVERT]) && led_pin_oe[0] == ($past(cfg_q[BIT_INVERT])
    || $past(cfg_q[BIT_STAGE]))) else $error("off code drive wrong");
  a_code_on: assert property ($past(reset_n && !output_enable_n && c0_q == CODE_ON) |->
    led_pin_out[0] == $past(cfg_q[BIT_INVERT]) && led_pin_oe[0] == (!$past(cfg_q[BIT_INVERT])
    || $past(cfg_q[BIT_STAGE]))) else $error("on code drive wrong");
endmodule // lopm_mixer_asserts
bind lopm_led_output_pwm_mixer lopm_mixer_asserts #(.NUM_CH(NUM_CH), .BLINK_PRESC(BLINK_PRESC)) u_chk (
  .clk(clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .output_enable_n(output_enable_n), .reg_rdata(reg_rdata),
  .led_pin_out(led_pin_out), .led_pin_oe(led_pin_oe));
`default_nettype wire

// *** tb/lopm_led_load.sv ***
`timescale 1ns/10ps
`default_nettype none
module lopm_led_load #(
  parameter int N = 16
) (
  input  wire logic [N-1:0] pin_out,
  input  wire logic [N-1:0] pin_oe,
  output logic      [N-1:0] lit
);
  // Pull-up through the LED: released pin rests high, LED lit when pin low
  assign lit = ~((pin_oe & pin_out) | ~pin_oe);
endmodule // lopm_led_load
`default_nettype wire

// *** tb/lopm_led_output_pwm_mixer_tb.sv ***
`timescale 1ns/10ps
`default_nettype none
module lopm_led_output_pwm_mixer_tb
  import lopm_pkg::*;
;
  logic        clk;
  logic        reset_n;
  logic [7:0]  reg_addr;
  logic [7:0]  reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic        output_enable_n;
  logic [7:0]  reg_rdata;
  logic [15:0] pout;
  logic [15:0] poe;
  logic [15:0] lit;
  int          num_errors;
  int          samples_checked;
  int          cycles;
  int          n;
  int          d;
  lopm_led_output_pwm_mixer #(.NUM_CH(16), .BLINK_PRESC(2)) uut (.clk(clk), .reset_n(reset_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .output_enable_n(output_enable_n),
    .reg_rdata(reg_rdata), .led_pin_out(pout), .led_pin_oe(poe));
  lopm_led_load #(.N(16)) load (.pin_out(pout), .pin_oe(poe), .lit(lit));
  ////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      num_errors++;
      print_verdict();
    end
  end
  task automatic print_verdict();
    if (num_errors == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    check(16'(reg_rdata), 16'(e));
    @(posedge clk);
  endtask
  task automatic measure(input logic [1:0] c, input logic [7:0] v, input int len, output int cnt);
    wr(ADDR_CODE_BASE, {4{c}});
    wr(ADDR_CH_BASE, v);
    repeat (len) @(posedge clk);
    cnt = 0;
    repeat (len) begin
      @(negedge clk);
      cnt += int'(lit[0]);
    end
    @(posedge clk);
  endtask
  function automatic int exp_lit(int c, int v, int inv);
    int r;
    r = (c == 0) ? 0 : (c == 1) ? 256 : (c == 2) ? v : 0;
    return inv ? 256 - r : r;
  endfunction
  ////////////////////////////////////////////////////////////////////////
  initial begin
    reset_n = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    output_enable_n = 1'b0;
    num_errors = 0;
    samples_checked = 0;
    cycles = 0;
    void'($urandom(32'h33908E09));
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    rd(ADDR_OUTCFG, RST_OUTCFG);
    rd(ADDR_GRP_DUTY, RST_GRP_DUTY);
    rd(8'h1F, 8'h00);
    rd(ADDR_STATUS, 8'h40);
    wr(ADDR_OUTCFG, 8'hFF);
    rd(ADDR_OUTCFG, 8'h37);
    wr(ADDR_GRP_DUTY, 8'h00);
    for (int m = 0; m < 4; m++) begin
      wr(ADDR_OUTCFG, 8'((m % 2) * 16 + (m / 2) * 4));
      for (int c = 0; c < 4; c++) begin
        d = $urandom_range(255, 0);
        if (c == 2 && m < 2) d = m * 255;
        measure(2'(c), 8'(d), 256, n);
        check(16'(n), 16'(exp_lit(c, d, m % 2)));
      end
    end
    rd(ADDR_CODE_BASE, 8'hFF);
    rd(ADDR_CH_BASE, 8'(d));
    wr(ADDR_OUTCFG, 8'h24);
    wr(ADDR_GRP_DUTY, 8'h80);
    for (int p = 0; p < 3; p++) begin
      wr(ADDR_GRP_PERIOD, 8'(p));
      measure(CODE_GRP, 8'hFF, 512 * (p + 1), n);
      check(16'(n), 16'(255 * (p + 1)));
    end
    rd(ADDR_GRP_PERIOD, 8'h02);
    output_enable_n <= 1'b1;
    wr(ADDR_GRP_DUTY, 8'h00);
    rd(ADDR_STATUS, 8'h80);
    for (int s = 0; s < 4; s++) begin
      wr(ADDR_OUTCFG, 8'(16 + s));
      repeat (3) @(posedge clk);
      @(negedge clk);
      check(lit, (s == 0) ? 16'hFFFF : 16'h0000);
      @(posedge clk);
    end
    print_verdict();
  end
endmodule // lopm_led_output_pwm_mixer_tb
`default_nettype wire
